/* lpmux_pkg.sv */
// Overview of operation
// - Rate field picks 50/100/200/500 ms blink period
// - Stretch disable drives activity straight from inputs
// - Options 0-3: link, plus any/tx/rx blink
// - Options 4-6: leader, follower, stretched activity
// - Option 9 link-loss latch, A error toggle, B errors
// - Force enable drives force value on pins a, b
// - Third force acts on clock pin as indicator
// - Polarity 0 active low, 1 active high
// - Strap at supply makes polarity default zero
// - Pin b alternate field: 2,3,6,7 signals
// - Pin a alternate field uses same codes
// - Clock pin field selects alternates, resets to 1
// - Bit 15 puts transmit error on pin b
// - Receive pad pull forced from bits 15:14
// - Transmit pad pull forced from bits 12:11
// - Bit 5 selects receive pad slew
// - Bit 0 selects transmit clock pad slew
// - Straps captured at power-up or reset, read-only
// - Reset sample of RX_D3 kept in bit 8
// - Two-bit mux: crystal, test clock, or configured signal
package lpmux_pkg;
	// Register indices; byte address is four times the index
	localparam logic [11:0] IDX_FUNC = 12'h0450;
	localparam logic [11:0] IDX_FORCE = 12'h0451;
	localparam logic [11:0] IDX_ALT1 = 12'h0452;
	localparam logic [11:0] IDX_ALT2 = 12'h0453;
	localparam logic [11:0] IDX_PAD = 12'h0456;
	localparam logic [11:0] IDX_STRAP = 12'h045D;
	localparam logic [11:0] IDX_CKMUX = 12'h045F;
	// Reset values
	localparam logic [15:0] RST_FUNC = 16'h2610;
	localparam logic [15:0] RST_FORCE = 16'h0049;
	localparam logic [15:0] RST_ALT1 = 16'h0000;
	localparam logic [15:0] RST_ALT2 = 16'h0001;
	localparam logic [15:0] RST_PAD = 16'h0000;
	localparam logic [15:0] RST_CKMUX = 16'h000C;
	// Writable bit masks
	localparam logic [15:0] MSK_FUNC = 16'h7FFF;
	localparam logic [15:0] MSK_FORCE = 16'h01FF;
	localparam logic [15:0] MSK_ALT1 = 16'h0707;
	localparam logic [15:0] MSK_ALT2 = 16'h8007;
	localparam logic [15:0] MSK_PAD = 16'hFC21;
	localparam logic [15:0] MSK_CKMUX = 16'h000F;
	// Field positions
	localparam int B_STR_DIS = 14;
	localparam int B_RATE = 12;
	localparam int B_TXER = 15;
	localparam int B_RX_PV = 14;
	localparam int B_RX_PF = 13;
	localparam int B_TX_PV = 11;
	localparam int B_TX_PF = 10;
	localparam int B_RX_SLEW = 5;
	localparam int B_TXC_SLEW = 0;
	localparam int B_B_MUX = 2;
	// Indicator option codes
	localparam logic [3:0] OPT_LINK = 4'h0;
	localparam logic [3:0] OPT_ANY = 4'h1;
	localparam logic [3:0] OPT_TX = 4'h2;
	localparam logic [3:0] OPT_RX = 4'h3;
	localparam logic [3:0] OPT_LEAD = 4'h4;
	localparam logic [3:0] OPT_FOLL = 4'h5;
	localparam logic [3:0] OPT_ACT = 4'h6;
	localparam logic [3:0] OPT_LOST = 4'h9;
	localparam logic [3:0] OPT_PRBS = 4'hA;
	localparam logic [3:0] OPT_XERR = 4'hB;
	// Alternate pin codes
	localparam logic [2:0] ALT_IND = 3'h1;
	localparam logic [2:0] ALT_WOL = 3'h2;
	localparam logic [2:0] ALT_UV = 3'h3;
	localparam logic [2:0] ALT_ESD = 3'h6;
	localparam logic [2:0] ALT_IRQ = 3'h7;
	// Pin mux codes
	localparam logic [1:0] MUX_XTAL = 2'h0;
	localparam logic [1:0] MUX_TCLK = 2'h1;
	localparam logic [1:0] MUX_CFG = 2'h3;
	// Timing
	localparam int CLK_NS = 50;
	localparam int MS_NS = 1000000;
	localparam int MS_CYC = MS_NS / CLK_NS;
	localparam logic [9:0] BLINK_MS_0 = 10'd50;
	localparam logic [9:0] BLINK_MS_1 = 10'd100;
	localparam logic [9:0] BLINK_MS_2 = 10'd200;
	localparam logic [9:0] BLINK_MS_3 = 10'd500;
	// Link-side status inputs
	typedef struct packed {
		logic link_good;
		logic leader;
		logic rx_dv;
		logic tx_ctrl;
		logic prbs_err;
		logic xmii_err;
		logic link_stat_read;
	} lpmux_stat_t;
	// Alternate pin sources
	typedef struct packed {
		logic wake_on_lan_signal;
		logic under_volt;
		logic esd_event;
		logic irq;
	} lpmux_alt_t;
	// Strap levels on the receive pins
	typedef struct packed {
		logic rx_d3;
		logic rx_d2;
		logic rx_d1;
		logic rx_d0;
		logic rx_clk;
		logic [1:0] rx_er;
		logic [1:0] rx_dv;
	} lpmux_strap_t;
endpackage : lpmux_pkg

/* lpmux_top.sv */
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module lpmux_top #(
	parameter int MS_CYCLES = lpmux_pkg::MS_CYC
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Link status and alternate sources
	input wire lpmux_pkg::lpmux_stat_t stat,
	input wire lpmux_pkg::lpmux_alt_t alt,
	input wire logic mii_tx_er,
	input wire logic crystal_input_clock,
	input wire logic test_transmit_clock,
	// Strap sampling
	input wire logic cold_boot,
	input wire lpmux_pkg::lpmux_strap_t straps,
	// Indicator pins
	input wire logic indicator_pin_a_i,
	output logic indicator_pin_a_o,
	output logic indicator_pin_a_oe_n,
	input wire logic indicator_pin_b_i,
	output logic indicator_pin_b_o,
	output logic indicator_pin_b_oe_n,
	output logic clock_output_pin,
	// MAC pad controls
	output logic [1:0] rx_pad_pull_select,
	output logic [1:0] tx_pad_pull_select,
	output logic rx_pad_slow,
	output logic txclk_pad_slow
);
	// Register file
	logic [15:0] func_r;
	logic [15:0] force_r;
	logic [15:0] alt1_r;
	logic [15:0] alt2_r;
	logic [15:0] pad_r;
	logic [15:0] ckmux_r;
	logic [15:0] strap_rst_r;   // Bits sampled at every reset
	logic [1:0] strap_pwr_r;    // Bits sampled at power-up only
	logic cap_done_r;           // Strap capture finished
	logic [31:0] prdata_r;
	// Activity and blink state
	logic [14:0] ms_cnt_r;
	logic ms_tick;
	logic [9:0] period_ms;
	logic [9:0] ph_cnt_r;
	logic phase_r;
	logic [9:0] act_ms_r;
	logic [9:0] tx_ms_r;
	logic [9:0] rx_ms_r;
	logic [9:0] err_ms_r;
	logic link_prev_r;
	logic lost_r;
	logic prbs_tgl_r;
	// Pin state
	logic pin_a_r;
	logic pin_b_r;
	logic pin_c_r;

	// Bus decode
	wire [11:0] idx = paddr[13:2];
	wire wr_en = psel && penable && pwrite;
	wire setup = psel && !penable;
	wire hit_func = idx == lpmux_pkg::IDX_FUNC;
	wire hit_force = idx == lpmux_pkg::IDX_FORCE;
	wire hit_alt1 = idx == lpmux_pkg::IDX_ALT1;
	wire hit_alt2 = idx == lpmux_pkg::IDX_ALT2;
	wire hit_pad = idx == lpmux_pkg::IDX_PAD;
	wire hit_strap = idx == lpmux_pkg::IDX_STRAP;
	wire hit_ckmux = idx == lpmux_pkg::IDX_CKMUX;
	wire hit = (hit_func || hit_force || hit_alt1 || hit_alt2 || hit_pad
		|| hit_strap || hit_ckmux) && paddr[1:0] == 2'b00 && paddr[15:14] == 2'b00;
	wire [15:0] bmask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
	// Strap register view
	wire [15:0] strap_rd = {2'b00, strap_pwr_r, 2'b00, strap_rst_r[9:0]};

	// Zero-wait slave, error on unmapped address
	assign pready = 1'b1;
	assign pslverr = psel && penable && !hit;
	assign prdata = prdata_r;

	// Read data is fetched in the setup phase
	wire [15:0] rd_mux = hit_func ? func_r : hit_force ? force_r :
		hit_alt1 ? alt1_r : hit_alt2 ? alt2_r : hit_pad ? pad_r :
		hit_strap ? strap_rd : hit_ckmux ? ckmux_r : 16'h0000;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h0000_0000;
		end else if (setup && !pwrite) begin
			prdata_r <= {16'h0000, hit ? rd_mux : 16'h0000};
		end
	end

	// Merge a write into a register under mask and strobes
	function automatic logic [15:0] merge(input logic [15:0] old,
		input logic [15:0] wd, input logic [15:0] msk, input logic [15:0] bm);
		merge = (old & ~(msk & bm)) | (wd & msk & bm);
	endfunction : merge

	// Writable configuration registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			func_r <= lpmux_pkg::RST_FUNC;
			alt1_r <= lpmux_pkg::RST_ALT1;
			alt2_r <= lpmux_pkg::RST_ALT2;
			pad_r <= lpmux_pkg::RST_PAD;
			ckmux_r <= lpmux_pkg::RST_CKMUX;
		end else if (wr_en && hit) begin
			if (hit_func) func_r <= merge(func_r, pwdata[15:0], lpmux_pkg::MSK_FUNC, bmask);
			if (hit_alt1) alt1_r <= merge(alt1_r, pwdata[15:0], lpmux_pkg::MSK_ALT1, bmask);
			if (hit_alt2) alt2_r <= merge(alt2_r, pwdata[15:0], lpmux_pkg::MSK_ALT2, bmask);
			if (hit_pad) pad_r <= merge(pad_r, pwdata[15:0], lpmux_pkg::MSK_PAD, bmask);
			if (hit_ckmux) ckmux_r <= merge(ckmux_r, pwdata[15:0], lpmux_pkg::MSK_CKMUX, bmask);
		end
	end

	// Force/polarity register; strap sets polarity defaults once after reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			force_r <= lpmux_pkg::RST_FORCE;
		end else if (!cap_done_r) begin
			force_r[0] <= !indicator_pin_a_i;
			force_r[3] <= !indicator_pin_b_i;
		end else if (wr_en && hit_force && hit) begin
			force_r <= merge(force_r, pwdata[15:0], lpmux_pkg::MSK_FORCE, bmask);
		end
	end

	// Strap capture in the first cycle after reset release
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cap_done_r <= 1'b0;
			strap_rst_r <= 16'h0000;
		end else if (!cap_done_r) begin
			cap_done_r <= 1'b1;
			strap_rst_r <= {6'h00, indicator_pin_a_i, straps.rx_d3, straps.rx_d2,
				straps.rx_d1, straps.rx_d0, straps.rx_clk, straps.rx_er,
				straps.rx_dv};
		end
	end

	// Power-up samples survive later resets, so they carry no reset
	always_ff @(posedge pclk) begin
		if (!cap_done_r && presetn && cold_boot) begin
			strap_pwr_r <= {indicator_pin_b_i, straps.rx_d3};
		end
	end

	// Millisecond tick divider
	assign ms_tick = ms_cnt_r == 15'(MS_CYCLES - 1);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) ms_cnt_r <= 15'h0000;
		else ms_cnt_r <= ms_tick ? 15'h0000 : ms_cnt_r + 15'h0001;
	end

	// Blink period from the rate field
	wire [1:0] rate = func_r[lpmux_pkg::B_RATE +: 2];
	assign period_ms = rate == 2'd0 ? lpmux_pkg::BLINK_MS_0 :
		rate == 2'd1 ? lpmux_pkg::BLINK_MS_1 :
		rate == 2'd2 ? lpmux_pkg::BLINK_MS_2 : lpmux_pkg::BLINK_MS_3;

	// Blink phase toggles once per period
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ph_cnt_r <= 10'h000;
			phase_r <= 1'b0;
		end else if (ms_tick) begin
			if (ph_cnt_r + 10'h001 >= period_ms) begin
				ph_cnt_r <= 10'h000;
				phase_r <= !phase_r;
			end else begin
				ph_cnt_r <= ph_cnt_r + 10'h001;
			end
		end
	end

	// Stretch counters: a pulse reloads a full period, ticks count down
	function automatic logic [9:0] hold(input logic [9:0] cnt, input logic ev,
		input logic tick, input logic [9:0] per);
		hold = ev ? per : (tick && cnt != 10'h000) ? cnt - 10'h001 : cnt;
	endfunction : hold
	wire any_act = stat.rx_dv || stat.tx_ctrl;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			act_ms_r <= 10'h000;
			tx_ms_r <= 10'h000;
			rx_ms_r <= 10'h000;
			err_ms_r <= 10'h000;
		end else begin
			act_ms_r <= hold(act_ms_r, any_act, ms_tick, period_ms);
			tx_ms_r <= hold(tx_ms_r, stat.tx_ctrl, ms_tick, period_ms);
			rx_ms_r <= hold(rx_ms_r, stat.rx_dv, ms_tick, period_ms);
			err_ms_r <= hold(err_ms_r, stat.xmii_err, ms_tick, period_ms);
		end
	end

	// Activity levels, direct when stretching is off
	wire str_dis = func_r[lpmux_pkg::B_STR_DIS];
	wire act_w = str_dis ? any_act : act_ms_r != 10'h000;
	wire tx_w = str_dis ? stat.tx_ctrl : tx_ms_r != 10'h000;
	wire rx_w = str_dis ? stat.rx_dv : rx_ms_r != 10'h000;
	wire err_w = str_dis ? stat.xmii_err : err_ms_r != 10'h000;
	// Direct mode shows the pulse itself, stretched mode blinks
	wire blk = str_dis ? 1'b1 : phase_r;

	// Link-loss latch and error toggle; a new loss beats a read clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			link_prev_r <= 1'b0;
			lost_r <= 1'b0;
			prbs_tgl_r <= 1'b0;
		end else begin
			link_prev_r <= stat.link_good;
			if (link_prev_r && !stat.link_good) lost_r <= 1'b1;
			else if (stat.link_stat_read) lost_r <= 1'b0;
			if (stat.prbs_err) prbs_tgl_r <= !prbs_tgl_r;
		end
	end

	// Indicator function for one option code, active-high
	function automatic logic ind_fn(input logic [3:0] opt, input logic lk,
		input logic ld, input logic a, input logic t, input logic r,
		input logic b, input logic lost, input logic pt, input logic e);
		case (opt)
			lpmux_pkg::OPT_LINK: ind_fn = lk;
			lpmux_pkg::OPT_ANY: ind_fn = lk && !(a && b);
			lpmux_pkg::OPT_TX: ind_fn = lk && !(t && b);
			lpmux_pkg::OPT_RX: ind_fn = lk && !(r && b);
			lpmux_pkg::OPT_LEAD: ind_fn = lk && ld;
			lpmux_pkg::OPT_FOLL: ind_fn = lk && !ld;
			lpmux_pkg::OPT_ACT: ind_fn = a;
			lpmux_pkg::OPT_LOST: ind_fn = lost;
			lpmux_pkg::OPT_PRBS: ind_fn = pt;
			lpmux_pkg::OPT_XERR: ind_fn = e;
			default: ind_fn = 1'b0;
		endcase
	endfunction : ind_fn

	// Per-indicator level after force and polarity
	logic [2:0] ind_w;
	logic [2:0] lvl_w;
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_ind
			assign ind_w[gi] = ind_fn(func_r[gi*4 +: 4], stat.link_good, stat.leader,
				act_w, tx_w, rx_w, blk, lost_r, prbs_tgl_r, err_w);
			assign lvl_w[gi] = force_r[gi*3+2] ? force_r[gi*3+1]
				: (ind_w[gi] ~^ force_r[gi*3]);
		end
	endgenerate

	// Alternate source for a three-bit configuration code
	function automatic logic alt_sel(input logic [2:0] c, input logic dflt,
		input lpmux_pkg::lpmux_alt_t s);
		case (c)
			lpmux_pkg::ALT_WOL: alt_sel = s.wake_on_lan_signal;
			lpmux_pkg::ALT_UV: alt_sel = s.under_volt;
			lpmux_pkg::ALT_ESD: alt_sel = s.esd_event;
			lpmux_pkg::ALT_IRQ: alt_sel = s.irq;
			default: alt_sel = dflt;
		endcase
	endfunction : alt_sel

	// Pin selection
	wire [2:0] cfg_a = alt1_r[2:0];
	wire [2:0] cfg_b = alt1_r[10:8];
	wire [2:0] cfg_c = alt2_r[2:0];
	wire [1:0] mux_b = ckmux_r[lpmux_pkg::B_B_MUX +: 2];
	wire [1:0] mux_c = ckmux_r[1:0];
	wire a_nxt = alt_sel(cfg_a, lvl_w[0], alt);
	wire b_cfg = alt_sel(cfg_b, lvl_w[1], alt);
	wire b_nxt = alt2_r[lpmux_pkg::B_TXER] ? mii_tx_er
		: mux_b == lpmux_pkg::MUX_CFG ? b_cfg : 1'b0;
	// Third indicator reaches the clock pin only with code 1
	wire c_nxt = cfg_c == lpmux_pkg::ALT_IND ? lvl_w[2]
		: alt_sel(cfg_c, 1'b0, alt);

	// Registered pin levels; pins released during strap capture
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_a_r <= 1'b0;
			pin_b_r <= 1'b0;
			pin_c_r <= 1'b0;
		end else begin
			pin_a_r <= a_nxt;
			pin_b_r <= b_nxt;
			pin_c_r <= c_nxt;
		end
	end
	wire b_clk = !alt2_r[lpmux_pkg::B_TXER] && mux_b != lpmux_pkg::MUX_CFG;
	assign indicator_pin_a_o = pin_a_r;
	assign indicator_pin_a_oe_n = !cap_done_r;
	assign indicator_pin_b_o = !b_clk ? pin_b_r
		: mux_b == lpmux_pkg::MUX_XTAL ? crystal_input_clock
		: mux_b == lpmux_pkg::MUX_TCLK ? test_transmit_clock : 1'b0;
	assign indicator_pin_b_oe_n = !cap_done_r;
	assign clock_output_pin = mux_c == lpmux_pkg::MUX_XTAL ? crystal_input_clock
		: mux_c == lpmux_pkg::MUX_TCLK ? test_transmit_clock
		: mux_c == lpmux_pkg::MUX_CFG ? pin_c_r : 1'b0;

	// Pad controls straight from register bits
	assign rx_pad_pull_select = pad_r[lpmux_pkg::B_RX_PF]
		? pad_r[lpmux_pkg::B_RX_PV +: 2] : 2'b00;
	assign tx_pad_pull_select = pad_r[lpmux_pkg::B_TX_PF]
		? pad_r[lpmux_pkg::B_TX_PV +: 2] : 2'b00;
	assign rx_pad_slow = pad_r[lpmux_pkg::B_RX_SLEW];
	assign txclk_pad_slow = pad_r[lpmux_pkg::B_TXC_SLEW];

	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_FORCE_A: assert property (cap_done_r && force_r[2] && cfg_a == 3'h0
		|=> indicator_pin_a_o == $past(force_r[1]))
		else $error("pin a ignores force value");
	AST_POL_A: assert property (cap_done_r && !force_r[2] && cfg_a == 3'h0
		|=> indicator_pin_a_o == ($past(ind_w[0]) ~^ $past(force_r[0])))
		else $error("pin a polarity wrong");
	AST_LOST_SET: assert property (link_prev_r && !stat.link_good |=> lost_r)
		else $error("link loss not latched");
	AST_LOST_HOLD: assert property (lost_r && !stat.link_stat_read |=> lost_r)
		else $error("link loss dropped without read");
	AST_STRETCH: assert property (any_act ##1 !any_act [*3] |-> act_w || str_dis
		|| $past(str_dis, 3))
		else $error("activity pulse not stretched");
	AST_DIRECT: assert property (cap_done_r && str_dis && !force_r[2]
		&& func_r[3:0] == lpmux_pkg::OPT_ACT && cfg_a == 3'h0
		|=> indicator_pin_a_o == ($past(any_act) ~^ $past(force_r[0])))
		else $error("direct activity mismatch");
	AST_TXER: assert property (alt2_r[15] && $stable(alt2_r[15])
		|-> indicator_pin_b_o == $past(mii_tx_er))
		else $error("pin b not carrying tx error");
	AST_RX_PULL: assert property (!pad_r[13] |-> rx_pad_pull_select == 2'b00)
		else $error("rx pull applied without force");
	AST_STRAP_POL: assert property ($rose(cap_done_r)
		|-> force_r[0] == !$past(indicator_pin_a_i))
		else $error("polarity default not from strap");
	AST_RATE: assert property (rate == 2'd3 && ms_tick && ph_cnt_r == 10'd499
		|=> phase_r != $past(phase_r))
		else $error("slow blink period wrong");
	COV_LOST: cover property (link_prev_r && !stat.link_good ##[1:20] stat.link_stat_read);
	COV_FORCE: cover property (force_r[5] && cap_done_r);
	COV_TXER: cover property (alt2_r[15] && mii_tx_er);
	COV_BLINK: cover property (act_w && $changed(phase_r));
endmodule : lpmux_top
`default_nettype wire

/* lpmux_lamp_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Board side of the indicator pins: lamps plus strap resistors
module lpmux_lamp_model #(
	parameter logic STRAP_A = 1'b1,
	parameter logic STRAP_B = 1'b0
) (
	// Device drive of the two-way pins
	input wire logic a_o,
	input wire logic a_oe_n,
	input wire logic b_o,
	input wire logic b_oe_n,
	// Resolved pin levels seen by lamps and device
	output logic a_lvl,
	output logic b_lvl
);
	// Undriven pin settles to its strap resistor level
	assign a_lvl = a_oe_n ? STRAP_A : a_o;
	assign b_lvl = b_oe_n ? STRAP_B : b_o;
endmodule : lpmux_lamp_model
`default_nettype wire

/* lpmux_top_test.sv */
`timescale 1ns/1ps
`default_nettype none
module lpmux_top_test;
	localparam int MSC = 4; // Cycles per shortened millisecond
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [15:0] paddr = 16'h0000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready, pslverr;
	lpmux_pkg::lpmux_stat_t stat = '0;
	lpmux_pkg::lpmux_alt_t alt = '0;
	logic tx_er = 1'b0, xtal = 1'b0, tclk = 1'b0, cold = 1'b1;
	lpmux_pkg::lpmux_strap_t straps = 9'h159; // Strap pattern on receive pins
	logic a_o, a_oe_n, b_o, b_oe_n, a_lvl, b_lvl, clk_pin;
	logic [1:0] rx_pull, tx_pull;
	logic rx_slow, txc_slow;
	int fails = 0, checks = 0;
	// Free-running bus clock
	always #25 pclk = ~pclk;
	lpmux_top #(.MS_CYCLES(MSC)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .stat(stat), .alt(alt),
		.mii_tx_er(tx_er), .crystal_input_clock(xtal), .test_transmit_clock(tclk),
		.cold_boot(cold), .straps(straps), .indicator_pin_a_i(a_lvl),
		.indicator_pin_a_o(a_o), .indicator_pin_a_oe_n(a_oe_n), .indicator_pin_b_i(b_lvl),
		.indicator_pin_b_o(b_o), .indicator_pin_b_oe_n(b_oe_n), .clock_output_pin(clk_pin),
		.rx_pad_pull_select(rx_pull), .tx_pad_pull_select(tx_pull), .rx_pad_slow(rx_slow),
		.txclk_pad_slow(txc_slow));
	// Pin a strapped to supply, pin b strapped low
	lpmux_lamp_model u_lamp (.a_o(a_o), .a_oe_n(a_oe_n), .b_o(b_o), .b_oe_n(b_oe_n),
		.a_lvl(a_lvl), .b_lvl(b_lvl));
	// Compare one result and count it
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// One APB transfer; holds the request until pready is seen high
	task automatic apb(input logic [11:0] idx, input logic w, input logic [15:0] wd,
		output logic [15:0] rd, output logic er);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= {16'h0000, wd};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata[15:0];
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [11:0] idx, input logic [15:0] d);
		logic [15:0] r;
		logic e;
		apb(idx, 1'b1, d, r, e);
	endtask : wr
	task automatic rdc(input string what, input logic [11:0] idx, input logic [15:0] exp);
		logic [15:0] r;
		logic e;
		apb(idx, 1'b0, 16'h0000, r, e);
		chk(what, exp, r);
	endtask : rdc
	// Program the indicator and mux registers
	task automatic cfg(input logic [15:0] f, input logic [15:0] p, input logic [15:0] a1,
		input logic [15:0] a2, input logic [15:0] m);
		wr(lpmux_pkg::IDX_FUNC, f);
		wr(lpmux_pkg::IDX_FORCE, p);
		wr(lpmux_pkg::IDX_ALT1, a1);
		wr(lpmux_pkg::IDX_ALT2, a2);
		wr(lpmux_pkg::IDX_CKMUX, m);
	endtask : cfg
	// Pin levels a, b, clock after the pipeline settles
	task automatic pins(input string what, input logic [2:0] exp);
		repeat (3) @(posedge pclk);
		@(negedge pclk);
		chk(what, {13'h0000, exp}, {13'h0000, a_lvl, b_lvl, clk_pin});
	endtask : pins
	task automatic t_reset();
		logic [11:0] ix [7] = '{lpmux_pkg::IDX_FUNC, lpmux_pkg::IDX_FORCE, lpmux_pkg::IDX_ALT1,
			lpmux_pkg::IDX_ALT2, lpmux_pkg::IDX_PAD, lpmux_pkg::IDX_STRAP, lpmux_pkg::IDX_CKMUX};
		logic [15:0] ev [7] = '{16'h2610, 16'h0048, 16'h0000, 16'h0001, 16'h0000, 16'h1359,
			16'h000C};
		logic [15:0] mk [7] = '{16'h7FFF, 16'h01FF, 16'h0707, 16'h8007, 16'hFC21, 16'h1359,
			16'h000F};
		logic [15:0] r;
		logic e;
		for (int k = 0; k < 7; k++) rdc("reset value", ix[k], ev[k]);
		apb(12'h0454, 1'b0, 16'h0000, r, e);
		chk("unmapped error", 16'h0001, {15'h0000, e});
		for (int k = 0; k < 7; k++) wr(ix[k], 16'hFFFF);
		for (int k = 0; k < 7; k++) rdc("writable bits", ix[k], mk[k]);
		$display("test reset done");
	endtask : t_reset
	task automatic t_link();
		cfg(16'h0000, 16'h0049, 16'h0000, 16'h0001, 16'h000F);
		@(posedge pclk);
		stat.link_good <= 1'b1;
		pins("link high", 3'b111);
		wr(lpmux_pkg::IDX_FORCE, 16'h0000);
		pins("link low", 3'b000);
		@(posedge pclk);
		stat.link_good <= 1'b0;
		wr(lpmux_pkg::IDX_FORCE, 16'h01EF);
		pins("forced", 3'b101);
		wr(lpmux_pkg::IDX_ALT2, 16'h0002);
		pins("force off clock", 3'b100);
		$display("test link done");
	endtask : t_link
	task automatic t_alt();
		logic [2:0] cd [4] = '{3'h2, 3'h3, 3'h6, 3'h7};
		cfg(16'h0000, 16'h0049, 16'h0000, 16'h0001, 16'h000F);
		for (int k = 0; k < 4; k++) begin
			wr(lpmux_pkg::IDX_ALT1, {5'h00, cd[k], 5'h00, cd[k]});
			wr(lpmux_pkg::IDX_ALT2, {13'h0000, cd[k]});
			@(posedge pclk);
			alt <= 4'h8 >> k;
			pins("alt on", 3'b111);
			@(posedge pclk);
			alt <= ~(4'h8 >> k);
			pins("alt off", 3'b000);
		end
		cfg(16'h0000, 16'h0049, 16'h0000, 16'h8001, 16'h000F);
		@(posedge pclk);
		stat.link_good <= 1'b1;
		pins("tx error low", 3'b101);
		@(posedge pclk);
		tx_er <= 1'b1;
		pins("tx error high", 3'b111);
		$display("test alternate done");
	endtask : t_alt
	task automatic t_mux();
		cfg(16'h0000, 16'h0049, 16'h0000, 16'h0001, 16'h0000);
		@(posedge pclk);
		stat.link_good <= 1'b0;
		tx_er <= 1'b0;
		xtal <= 1'b1;
		pins("crystal", 3'b011);
		@(posedge pclk);
		xtal <= 1'b0;
		tclk <= 1'b1;
		pins("crystal low", 3'b000);
		wr(lpmux_pkg::IDX_CKMUX, 16'h0005);
		pins("test clock", 3'b011);
		wr(lpmux_pkg::IDX_PAD, 16'h7421);
		@(negedge pclk);
		chk("pads", 16'h001B, {10'h000, rx_pull, tx_pull, rx_slow, txc_slow});
		wr(lpmux_pkg::IDX_PAD, 16'h5800);
		@(negedge pclk);
		chk("pads unforced", 16'h0000, {10'h000, rx_pull, tx_pull, rx_slow, txc_slow});
		$display("test mux done");
	endtask : t_mux
	task automatic t_blink();
		int per [4] = '{50, 100, 200, 500};
		cfg(16'h0000, 16'h0049, 16'h0000, 16'h0001, 16'h000C);
		for (int r = 0; r < 4; r++) begin
			wr(lpmux_pkg::IDX_FUNC, {2'b00, r[1:0], 12'h006});
			@(posedge pclk);
			stat.rx_dv <= 1'b1;
			@(posedge pclk);
			stat.rx_dv <= 1'b0;
			repeat (per[r] * MSC - 6) @(posedge pclk);
			pins("stretch held", 3'b100);
			repeat (MSC + 6) @(posedge pclk);
			pins("stretch over", 3'b000);
		end
		wr(lpmux_pkg::IDX_FUNC, 16'h4006);
		@(posedge pclk);
		stat.tx_ctrl <= 1'b1;
		pins("direct on", 3'b100);
		@(posedge pclk);
		stat.tx_ctrl <= 1'b0;
		pins("direct off", 3'b000);
		$display("test blink done");
	endtask : t_blink
	task automatic t_status();
		cfg(16'h0054, 16'h0049, 16'h0000, 16'h0001, 16'h000F);
		@(posedge pclk);
		stat.link_good <= 1'b1;
		stat.leader <= 1'b1;
		pins("leader", 3'b101);
		@(posedge pclk);
		stat.leader <= 1'b0;
		pins("follower", 3'b011);
		wr(lpmux_pkg::IDX_FUNC, 16'h0BA9);
		@(posedge pclk);
		stat.link_stat_read <= 1'b1;
		@(posedge pclk);
		stat.link_stat_read <= 1'b0;
		pins("status idle", 3'b000);
		@(posedge pclk);
		stat.link_good <= 1'b0;
		pins("link lost", 3'b100);
		@(posedge pclk);
		stat.link_good <= 1'b1;
		pins("lost held", 3'b100);
		@(posedge pclk);
		stat.link_stat_read <= 1'b1;
		@(posedge pclk);
		stat.link_stat_read <= 1'b0;
		stat.prbs_err <= 1'b1;
		@(posedge pclk);
		stat.prbs_err <= 1'b0;
		stat.xmii_err <= 1'b1;
		@(posedge pclk);
		stat.xmii_err <= 1'b0;
		pins("error toggle", 3'b011);
		$display("test status done");
	endtask : t_status
	task automatic t_warm();
		@(posedge pclk);
		presetn <= 1'b0;
		cold <= 1'b0;
		straps.rx_d3 <= 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		rdc("warm strap", lpmux_pkg::IDX_STRAP, 16'h1259);
		$display("test warm reset done");
	endtask : t_warm
	// Counts, verdict and end of run
	task automatic complete_run();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : complete_run
	// Main sequence
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		t_reset();
		t_link();
		t_alt();
		t_mux();
		t_blink();
		t_status();
		t_warm();
		complete_run();
	end
	// Watchdog against a hang
	initial begin
		repeat (40000) @(posedge pclk);
		fails++;
		$display("ERROR watchdog expected finish seen hang");
		complete_run();
	end
endmodule : lpmux_top_test
`default_nettype wire
